// >>> verilog/trap_csr_pkg.sv
// Purpose: constants for the machine trap and trigger register set
// Assumes: 32-bit core, one breakpoint trigger, one event counter
// Notes: register offsets are 12-bit register addresses
//
// What this block does
// - Fast interrupt enables in bits 31:16, reset zero
// - Enable bits 11,7,3 gate external, timer, software
// - Vector base bits 31:8 writable, 7:1 zero
// - Vector bit 0 picks direct or vectored
// - Vector resets to boot base, mode 01
// - Traps fetch from handler built on base
// - Counter inhibit resets stopping every counter
// - Inhibit bits 0,2,3 writable; others zero
// - Event selectors sixteen bits; unimplemented read zero
// - Exception entry saves pc, bit 0 zero
// - Trap return reloads pc from saved pc
// - Cause: bit 31 interrupt, code 4:0
// - Trap value ignores writes, reads zero
// - Pending register mirrors request lines
// - Trigger select reads zero; machine or debug only
// - Trigger control fixed pattern, bit 2 writable
// - Trigger data writes need debug mode
// - Match address register holds 32-bit address
// - Enabled match in machine mode enters debug
// - Trigger extra data reads zero
// - Type info reads 4; the absent value 1 is never returned
`default_nettype none
package trap_csr_pkg;
    localparam logic [11:0] INTERRUPT_ENABLE_ADDR = 12'h304;
    localparam logic [11:0] TRAP_VECTOR_BASE_ADDR = 12'h305;
    localparam logic [11:0] COUNTER_INHIBIT_ADDR = 12'h320;
    localparam logic [11:0] EVENT_SELECTOR_ADDR = 12'h323;
    localparam logic [11:0] EVENT_SELECTOR_LAST_ADDR = 12'h33f;
    localparam logic [11:0] TRAP_SCRATCH_ADDR = 12'h340;
    localparam logic [11:0] EXCEPTION_PC_ADDR = 12'h341;
    localparam logic [11:0] TRAP_CAUSE_ADDR = 12'h342;
    localparam logic [11:0] TRAP_VALUE_ADDR = 12'h343;
    localparam logic [11:0] INTERRUPT_PENDING_ADDR = 12'h344;
    localparam logic [11:0] TRIGGER_SELECT_ADDR = 12'h7a0;
    localparam logic [11:0] TRIGGER_CONTROL_ADDR = 12'h7a1;
    localparam logic [11:0] TRIGGER_MATCH_ADDRESS_ADDR = 12'h7a2;
    localparam logic [11:0] TRIGGER_EXTRA_DATA_ADDR = 12'h7a3;
    localparam logic [11:0] TRIGGER_TYPE_INFO_ADDR = 12'h7a4;
    localparam logic [31:0] IRQ_ENABLE_MASK = 32'hffff_0888;
    localparam logic [31:0] COUNTER_INHIBIT_RESET = 32'h0000_000d;
    localparam logic [31:0] COUNTER_INHIBIT_FIXED_MASK = 32'h0000_0005;
    localparam int INHIBIT_FIRST_EVENT_BIT = 3;
    localparam int EVENT_SELECT_WIDTH = 16;
    localparam logic [31:0] TRIGGER_CONTROL_RESET = 32'h2800_1040;
    localparam int TRIGGER_EXECUTE_BIT = 2;
    localparam logic [31:0] TRIGGER_INFO_VALUE = 32'h0000_0004;
    localparam logic [31:0] TRIGGER_INFO_ABSENT = 32'h0000_0001;
    localparam int VECTOR_BASE_LSB = 8;
    localparam logic [1:0] VECTOR_MODE_RESET = 2'h1;
    localparam int CAUSE_CODE_WIDTH = 5;
    localparam logic [4:0] CAUSE_DEBUG_TRIGGER = 5'h02;
    localparam logic [1:0] PRIV_MACHINE = 2'h3;
    typedef enum logic [1:0] {
        CSR_NONE = 2'b00,
        CSR_WRITE = 2'b01,
        CSR_SET = 2'b10,
        CSR_CLEAR = 2'b11
    } csr_op_e;
endpackage
`default_nettype wire

// >>> verilog/machine_trap_trigger_csrs.sv
// Purpose: machine trap, interrupt and breakpoint trigger registers
// Assumes: pipeline gives one access and at most one trap event per cycle
// Notes: read data is registered, one cycle after the access
`timescale 1ns/1ps
`default_nettype none
module machine_trap_trigger_csrs #(
    parameter int NUM_EVENT_COUNTERS = 1
) (
    input wire logic sysClk,
    input wire logic srst,
    input wire logic [31:0] bootVector,
    input wire logic [31:0] irqLines,
    input wire logic [11:0] csrAddr,
    input wire logic [1:0] csrOp,
    input wire logic [31:0] csrWdata,
    input wire logic debugMode,
    input wire logic [1:0] privLevel,
    input wire logic trapException,
    input wire logic [4:0] exceptionCode,
    input wire logic trapInterrupt,
    input wire logic trapReturn,
    input wire logic [31:0] currentPc,
    input wire logic fetchValid,
    input wire logic [31:0] fetchAddr,
    output logic [31:0] csrRdata,
    output logic [31:0] counterInhibit,
    output logic irqRequest,
    output logic pcLoad,
    output logic [31:0] pcTarget,
    output logic debugTriggerHit
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] irqEnable_r;
    logic [31:8] vectorBase_r;
    logic vectorMode_r;
    logic [31:0] inhibit_r;
    logic [15:0] eventSel_r [0:28];
    logic [31:0] scratch_r;
    logic [31:1] epc_r;
    logic causeIrq_r;
    logic [4:0] causeCode_r;
    logic triggerExec_r;
    logic [31:0] triggerAddr_r;
    logic bootSeen_r;
    logic [31:0] pendingEnabled;
    logic [4:0] irqId;
    logic [31:0] oldValue;
    logic [31:0] newValue;
    logic csrWr;
    logic triggerAccessOk;
    logic [4:0] eventIdx;
    logic eventHit;
    logic [31:0] vectorRead;
    logic [31:0] trapTarget;

    assign csrWr = (csrOp != 2'(trap_csr_pkg::CSR_NONE));
    // Trigger registers are only reachable from debug or machine mode
    assign triggerAccessOk = debugMode || (privLevel == trap_csr_pkg::PRIV_MACHINE);
    assign eventHit = (csrAddr >= trap_csr_pkg::EVENT_SELECTOR_ADDR) &&
                      (csrAddr <= trap_csr_pkg::EVENT_SELECTOR_LAST_ADDR);
    assign eventIdx = 5'(csrAddr - trap_csr_pkg::EVENT_SELECTOR_ADDR);
    assign vectorRead = {vectorBase_r, 7'h00, vectorMode_r};
    assign pendingEnabled = irqLines & irqEnable_r & trap_csr_pkg::IRQ_ENABLE_MASK;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        oldValue = 32'h0;
        if (eventHit) begin
            if (32'(eventIdx) < NUM_EVENT_COUNTERS) begin
                oldValue = {16'h0, eventSel_r[eventIdx]};
            end
        end else begin
            unique case (csrAddr)
                trap_csr_pkg::INTERRUPT_ENABLE_ADDR: oldValue = irqEnable_r;
                trap_csr_pkg::TRAP_VECTOR_BASE_ADDR: oldValue = vectorRead;
                trap_csr_pkg::COUNTER_INHIBIT_ADDR: oldValue = inhibit_r;
                trap_csr_pkg::TRAP_SCRATCH_ADDR: oldValue = scratch_r;
                trap_csr_pkg::EXCEPTION_PC_ADDR: oldValue = {epc_r, 1'b0};
                trap_csr_pkg::TRAP_CAUSE_ADDR: oldValue = {causeIrq_r, 26'h0, causeCode_r};
                trap_csr_pkg::TRAP_VALUE_ADDR: oldValue = 32'h0;
                trap_csr_pkg::INTERRUPT_PENDING_ADDR:
                    oldValue = irqLines & trap_csr_pkg::IRQ_ENABLE_MASK;
                trap_csr_pkg::TRIGGER_SELECT_ADDR: oldValue = 32'h0;
                trap_csr_pkg::TRIGGER_CONTROL_ADDR:
                    oldValue = trap_csr_pkg::TRIGGER_CONTROL_RESET |
                               {29'h0, triggerExec_r, 2'h0};
                trap_csr_pkg::TRIGGER_MATCH_ADDRESS_ADDR: oldValue = triggerAddr_r;
                trap_csr_pkg::TRIGGER_EXTRA_DATA_ADDR: oldValue = 32'h0;
                trap_csr_pkg::TRIGGER_TYPE_INFO_ADDR:
                    oldValue = trap_csr_pkg::TRIGGER_INFO_VALUE;
                default: oldValue = 32'h0;
            endcase
            if (csrAddr[11:4] == trap_csr_pkg::TRIGGER_SELECT_ADDR[11:4] && !triggerAccessOk) begin
                oldValue = 32'h0;
            end
        end
    end

    always_comb begin
        unique case (trap_csr_pkg::csr_op_e'(csrOp))
            trap_csr_pkg::CSR_WRITE: newValue = csrWdata;
            trap_csr_pkg::CSR_SET: newValue = oldValue | csrWdata;
            trap_csr_pkg::CSR_CLEAR: newValue = oldValue & ~csrWdata;
            default: newValue = oldValue;
        endcase
    end

    // ------------------------------------------------------------
    // Interrupt selection, highest line number wins
    // ------------------------------------------------------------
    always_comb begin
        irqId = 5'h0;
        for (int i = 0; i < 32; i++) begin
            if (pendingEnabled[i]) begin
                irqId = 5'(i);
            end
        end
    end

    // Vectored mode offsets only interrupts; exceptions stay at base
    always_comb begin
        trapTarget = {vectorBase_r, 8'h00};
        if (trapInterrupt && vectorMode_r) begin
            trapTarget = {vectorBase_r, 8'h00} + {25'h0, irqId, 2'h0};
        end
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge sysClk) begin
        if (srst) begin
            irqEnable_r <= 32'h0;
        end else if (csrWr && csrAddr == trap_csr_pkg::INTERRUPT_ENABLE_ADDR) begin
            irqEnable_r <= newValue & trap_csr_pkg::IRQ_ENABLE_MASK;
        end
    end

    // Boot vector is taken in reset and again on the first free edge
    always_ff @(posedge sysClk) begin
        if (srst) begin
            bootSeen_r <= 1'b0;
            // Loading in reset keeps a trap on the first free edge off address zero
            vectorBase_r <= bootVector[31:trap_csr_pkg::VECTOR_BASE_LSB];
            vectorMode_r <= trap_csr_pkg::VECTOR_MODE_RESET[0];
        end else if (!bootSeen_r) begin
            bootSeen_r <= 1'b1;
            vectorBase_r <= bootVector[31:trap_csr_pkg::VECTOR_BASE_LSB];
        end else if (csrWr && csrAddr == trap_csr_pkg::TRAP_VECTOR_BASE_ADDR) begin
            vectorBase_r <= newValue[31:trap_csr_pkg::VECTOR_BASE_LSB];
            vectorMode_r <= newValue[0];
        end
    end

    always_ff @(posedge sysClk) begin
        if (srst) begin
            inhibit_r <= trap_csr_pkg::COUNTER_INHIBIT_RESET;
        end else if (csrWr && csrAddr == trap_csr_pkg::COUNTER_INHIBIT_ADDR) begin
            for (int b = 0; b < 32; b++) begin
                if (b < trap_csr_pkg::INHIBIT_FIRST_EVENT_BIT + NUM_EVENT_COUNTERS) begin
                    inhibit_r[b] <= newValue[b] &
                        (trap_csr_pkg::COUNTER_INHIBIT_FIXED_MASK[b] ||
                         b >= trap_csr_pkg::INHIBIT_FIRST_EVENT_BIT);
                end else begin
                    inhibit_r[b] <= 1'b0;
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 29; g++) begin : gEvent
            always_ff @(posedge sysClk) begin
                if (srst) begin
                    eventSel_r[g] <= 16'h0;
                end else if (csrWr && eventHit && eventIdx == 5'(g) && g < NUM_EVENT_COUNTERS) begin
                    eventSel_r[g] <= newValue[trap_csr_pkg::EVENT_SELECT_WIDTH-1:0];
                end
            end
        end
    endgenerate

    always_ff @(posedge sysClk) begin
        if (srst) begin
            scratch_r <= 32'h0;
        end else if (csrWr && csrAddr == trap_csr_pkg::TRAP_SCRATCH_ADDR) begin
            scratch_r <= newValue;
        end
    end

    // Trap entry wins over a register write in the same cycle
    always_ff @(posedge sysClk) begin
        if (srst) begin
            epc_r <= 31'h0;
        end else if (trapException || trapInterrupt) begin
            epc_r <= currentPc[31:1];
        end else if (csrWr && csrAddr == trap_csr_pkg::EXCEPTION_PC_ADDR) begin
            epc_r <= newValue[31:1];
        end
    end

    // Illegal codes written by software are stored as given
    always_ff @(posedge sysClk) begin
        if (srst) begin
            causeIrq_r <= 1'b0;
            causeCode_r <= 5'h0;
        end else if (trapInterrupt) begin
            causeIrq_r <= 1'b1;
            causeCode_r <= irqId;
        end else if (trapException) begin
            causeIrq_r <= 1'b0;
            causeCode_r <= exceptionCode;
        end else if (csrWr && csrAddr == trap_csr_pkg::TRAP_CAUSE_ADDR) begin
            causeIrq_r <= newValue[31];
            causeCode_r <= newValue[trap_csr_pkg::CAUSE_CODE_WIDTH-1:0];
        end
    end

    always_ff @(posedge sysClk) begin
        if (srst) begin
            triggerExec_r <= trap_csr_pkg::TRIGGER_CONTROL_RESET[trap_csr_pkg::TRIGGER_EXECUTE_BIT];
            triggerAddr_r <= 32'h0;
        end else if (csrWr && debugMode) begin
            if (csrAddr == trap_csr_pkg::TRIGGER_CONTROL_ADDR) begin
                triggerExec_r <= newValue[trap_csr_pkg::TRIGGER_EXECUTE_BIT];
            end
            if (csrAddr == trap_csr_pkg::TRIGGER_MATCH_ADDRESS_ADDR) begin
                triggerAddr_r <= newValue;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge sysClk) begin
        if (srst) begin
            csrRdata <= 32'h0;
            counterInhibit <= trap_csr_pkg::COUNTER_INHIBIT_RESET;
            irqRequest <= 1'b0;
        end else begin
            csrRdata <= oldValue;
            counterInhibit <= inhibit_r;
            irqRequest <= |pendingEnabled;
        end
    end

    always_ff @(posedge sysClk) begin
        if (srst) begin
            pcLoad <= 1'b0;
            pcTarget <= 32'h0;
        end else begin
            pcLoad <= trapException || trapInterrupt || trapReturn;
            if (trapException || trapInterrupt) begin
                pcTarget <= trapTarget;
            end else if (trapReturn) begin
                pcTarget <= {epc_r, 1'b0};
            end
        end
    end

    // Exact whole-address compare, break before execution, machine mode only
    always_ff @(posedge sysClk) begin
        if (srst) begin
            debugTriggerHit <= 1'b0;
        end else begin
            debugTriggerHit <= fetchValid && triggerExec_r && !debugMode &&
                               privLevel == trap_csr_pkg::PRIV_MACHINE &&
                               fetchAddr == triggerAddr_r;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_trapEvent;
        trapException && !trapInterrupt;
    endsequence
    sequence s_handlerJump;
        pcLoad && pcTarget[7:0] == 8'h00;
    endsequence
    property p_excEntry;
        @(posedge sysClk) disable iff (srst) s_trapEvent |=> s_handlerJump;
    endproperty
    a_excEntry: assert property (p_excEntry) else $error("exception target not at base");
    property p_epcSave;
        @(posedge sysClk) disable iff (srst)
            trapException |=> {epc_r, 1'b0} == ($past(currentPc) & 32'hffff_fffe);
    endproperty
    a_epcSave: assert property (p_epcSave) else $error("pc not saved on exception");
    property p_mret;
        @(posedge sysClk) disable iff (srst)
            trapReturn && !trapException && !trapInterrupt |=> pcLoad && pcTarget == {$past(epc_r), 1'b0};
    endproperty
    a_mret: assert property (p_mret) else $error("return target wrong");
    property p_vecZero;
        @(posedge sysClk) disable iff (srst)
            $past(csrAddr) == trap_csr_pkg::TRAP_VECTOR_BASE_ADDR |-> csrRdata[7:1] == 7'h0;
    endproperty
    a_vecZero: assert property (p_vecZero) else $error("vector low bits nonzero");
    property p_trigGuard;
        @(posedge sysClk) disable iff (srst)
            !debugMode |=> $stable(triggerAddr_r) && $stable(triggerExec_r);
    endproperty
    a_trigGuard: assert property (p_trigGuard) else $error("trigger changed outside debug");
    property p_trigHit;
        @(posedge sysClk) disable iff (srst)
            fetchValid && triggerExec_r && !debugMode && privLevel == trap_csr_pkg::PRIV_MACHINE &&
            fetchAddr == triggerAddr_r |=> debugTriggerHit;
    endproperty
    a_trigHit: assert property (p_trigHit) else $error("trigger missed");
    property p_causeIrq;
        @(posedge sysClk) disable iff (srst) trapInterrupt |=> causeIrq_r ##0 causeCode_r == $past(irqId);
    endproperty
    a_causeIrq: assert property (p_causeIrq) else $error("cause wrong on interrupt");
    property p_enableMask;
        @(posedge sysClk) disable iff (srst) (irqEnable_r & ~trap_csr_pkg::IRQ_ENABLE_MASK) == 32'h0;
    endproperty
    a_enableMask: assert property (p_enableMask) else $error("enable reserved bit set");
    property p_inhibitBit1;
        @(posedge sysClk) disable iff (srst) counterInhibit[1] == 1'b0;
    endproperty
    a_inhibitBit1: assert property (p_inhibitBit1) else $error("inhibit bit 1 set");
    // Reads are checked at the port, so a broken read mux shows up here
    property p_valueZero;
        @(posedge sysClk) disable iff (srst)
            $past(csrAddr) == trap_csr_pkg::TRAP_VALUE_ADDR |-> csrRdata == 32'h0;
    endproperty
    a_valueZero: assert property (p_valueZero) else $error("trap value read nonzero");
    property p_pendingMirror;
        @(posedge sysClk) disable iff (srst)
            $past(csrAddr) == trap_csr_pkg::INTERRUPT_PENDING_ADDR |->
            csrRdata == ($past(irqLines) & trap_csr_pkg::IRQ_ENABLE_MASK);
    endproperty
    a_pendingMirror: assert property (p_pendingMirror) else $error("pending read differs from lines");
    property p_vecReset;
        @(posedge sysClk) disable iff (srst)
            $fell(srst) |-> vectorRead == {bootVector[31:trap_csr_pkg::VECTOR_BASE_LSB], 8'h01};
    endproperty
    a_vecReset: assert property (p_vecReset) else $error("vector not at boot base after reset");
endmodule
`default_nettype wire

// >>> bench/pipeline_model.sv
// Purpose: pipeline side model issuing register accesses and trap events
// Assumes: requests launch on the rising edge and are sampled on the next
// Notes: idle write data is inverted so a stale value never looks valid
`timescale 1ns/1ps
`default_nettype none
module pipeline_model (
    input wire logic sysClk,
    input wire logic [31:0] csrRdata,
    output logic [11:0] csrAddr,
    output logic [1:0] csrOp,
    output logic [31:0] csrWdata,
    output logic trapException,
    output logic [4:0] exceptionCode,
    output logic trapInterrupt,
    output logic trapReturn,
    output logic [31:0] currentPc,
    output logic fetchValid,
    output logic [31:0] fetchAddr
);
    // ------------------------------------------------------------
    // Request drivers
    // ------------------------------------------------------------
    initial begin
        csrAddr = 12'h000;
        csrOp = 2'h0;
        csrWdata = 32'h0000_0000;
        trapException = 1'b0;
        exceptionCode = 5'h00;
        trapInterrupt = 1'b0;
        trapReturn = 1'b0;
        currentPc = 32'h0000_0000;
        fetchValid = 1'b0;
        fetchAddr = 32'h0000_0000;
    end
    // Callers hand in legal cause codes only
    task automatic csr_write(input logic [11:0] a, input trap_csr_pkg::csr_op_e op, input logic [31:0] d);
        @(posedge sysClk);
        csrAddr <= a;
        csrOp <= op;
        csrWdata <= d;
        @(posedge sysClk);
        csrOp <= trap_csr_pkg::CSR_NONE;
        csrWdata <= ~d;
        #1;
    endtask
    // Read data is registered, so it is taken one edge after the address
    task automatic csr_read(input logic [11:0] a, output logic [31:0] v);
        @(posedge sysClk);
        csrAddr <= a;
        csrOp <= trap_csr_pkg::CSR_NONE;
        @(posedge sysClk);
        #1;
        v = csrRdata;
    endtask
    // Kind: 0 exception, 1 interrupt, 2 return, 3 fetch
    task automatic event_pulse(input int k, input logic [31:0] pc, input logic [4:0] code);
        @(posedge sysClk);
        currentPc <= pc;
        fetchAddr <= pc;
        exceptionCode <= code;
        case (k)
            0: trapException <= 1'b1;
            1: trapInterrupt <= 1'b1;
            2: trapReturn <= 1'b1;
            default: fetchValid <= 1'b1;
        endcase
        @(posedge sysClk);
        trapException <= 1'b0;
        trapInterrupt <= 1'b0;
        trapReturn <= 1'b0;
        fetchValid <= 1'b0;
        fetchAddr <= ~pc;
        #1;
    endtask
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Purpose: self-checking bench for the trap and trigger register set
// Assumes: one event counter, boot base fixed for the whole run
// Notes: all expectations come from the register layout, not the design
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic sysClk, srst, debugMode;
    logic [31:0] bootVector, irqLines, v, wd;
    logic [1:0] privLevel;
    logic [11:0] csrAddr;
    logic [1:0] csrOp;
    logic [31:0] csrWdata, currentPc, fetchAddr, csrRdata, counterInhibit, pcTarget;
    logic trapException, trapInterrupt, trapReturn, fetchValid, irqRequest, pcLoad, debugTriggerHit;
    logic [4:0] exceptionCode;
    int errCount = 0;
    int testsRun = 0;
    logic [11:0] ra [16] = '{12'h304, 12'h305, 12'h320, 12'h323, 12'h324, 12'h340, 12'h341, 12'h342,
        12'h343, 12'h344, 12'h7a0, 12'h7a1, 12'h7a2, 12'h7a3, 12'h7a4, 12'h3ff};
    logic [31:0] rr [16] = '{32'h0, 32'h1234_5601, 32'hd, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h2800_1040, 32'h0, 32'h0, 32'h4, 32'h0};
    logic [31:0] rw [16] = '{32'hffff_0888, 32'hffff_ff01, 32'hd, 32'hffff, 32'h0, 32'hffff_ffff,
        32'hffff_fffe, 32'h8000_000b, 32'h0, 32'h0, 32'h0, 32'h2800_1040, 32'h0, 32'h0, 32'h4, 32'h0};
    machine_trap_trigger_csrs #(.NUM_EVENT_COUNTERS(1)) i_dut (.sysClk(sysClk), .srst(srst),
        .bootVector(bootVector), .irqLines(irqLines), .csrAddr(csrAddr), .csrOp(csrOp),
        .csrWdata(csrWdata), .debugMode(debugMode), .privLevel(privLevel), .trapException(trapException),
        .exceptionCode(exceptionCode), .trapInterrupt(trapInterrupt), .trapReturn(trapReturn),
        .currentPc(currentPc), .fetchValid(fetchValid), .fetchAddr(fetchAddr), .csrRdata(csrRdata),
        .counterInhibit(counterInhibit), .irqRequest(irqRequest), .pcLoad(pcLoad), .pcTarget(pcTarget),
        .debugTriggerHit(debugTriggerHit));
    pipeline_model i_pipe (.sysClk(sysClk), .csrRdata(csrRdata), .csrAddr(csrAddr), .csrOp(csrOp),
        .csrWdata(csrWdata), .trapException(trapException), .exceptionCode(exceptionCode),
        .trapInterrupt(trapInterrupt), .trapReturn(trapReturn), .currentPc(currentPc),
        .fetchValid(fetchValid), .fetchAddr(fetchAddr));
    // ------------------------------------------------------------
    // Checking and verdict
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errCount++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", testsRun, errCount);
        if (errCount == 0 && testsRun > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        i_pipe.csr_read(a, v);
        check("register", v, exp);
    endtask
    task automatic trap(input int k, input logic [31:0] pc, input logic [4:0] c, input logic [31:0] t);
        i_pipe.event_pulse(k, pc, c);
        check("pc_load", {31'h0, pcLoad}, 32'h1);
        check("pc_target", pcTarget, t);
    endtask
    // ------------------------------------------------------------
    // Clock, watchdog and tests
    // ------------------------------------------------------------
    initial begin
        sysClk = 1'b0;
        forever #4 sysClk = ~sysClk;
    end
    // Whole run is under two hundred cycles; this leaves wide margin
    initial begin
        #50000;
        errCount++;
        conclude();
    end
    initial begin
        srst = 1'b1;
        bootVector = 32'h1234_5678;
        irqLines = 32'h0000_0000;
        debugMode = 1'b0;
        privLevel = trap_csr_pkg::PRIV_MACHINE;
        repeat (10) @(posedge sysClk);
        srst <= 1'b0;
        repeat (2) @(posedge sysClk);
        #1;
        check("inhibit_port", counterInhibit, 32'h0000_000d);
        for (int i = 0; i < 16; i++) begin
            rd(ra[i], rr[i]);
        end
        for (int i = 0; i < 16; i++) begin
            wd = (ra[i] == trap_csr_pkg::TRAP_CAUSE_ADDR) ? 32'h8000_000b : 32'hffff_ffff;
            i_pipe.csr_write(ra[i], trap_csr_pkg::CSR_WRITE, wd);
            rd(ra[i], rw[i]);
        end
        i_pipe.csr_write(12'h320, trap_csr_pkg::CSR_CLEAR, 32'h0000_0001);
        rd(12'h320, 32'h0000_000c);
        check("inhibit_port", counterInhibit, 32'h0000_000c);
        @(posedge sysClk) irqLines <= 32'hffff_ffff;
        rd(12'h344, 32'hffff_0888);
        @(posedge sysClk) irqLines <= 32'h0001_0080;
        rd(12'h344, 32'h0001_0080);
        check("irq_request", {31'h0, irqRequest}, 32'h1);
        trap(1, 32'h0000_2000, 5'h00, 32'hffff_ff40);
        rd(12'h342, 32'h8000_0010);
        trap(0, 32'h0000_3333, 5'h05, 32'hffff_ff00);
        rd(12'h341, 32'h0000_3332);
        rd(12'h342, 32'h0000_0005);
        trap(2, 32'h0000_0000, 5'h00, 32'h0000_3332);
        i_pipe.csr_write(12'h305, trap_csr_pkg::CSR_WRITE, 32'h0000_4400);
        rd(12'h305, 32'h0000_4400);
        trap(1, 32'h0000_2000, 5'h00, 32'h0000_4400);
        i_pipe.csr_write(12'h304, trap_csr_pkg::CSR_CLEAR, 32'hffff_ffff);
        rd(12'h304, 32'h0000_0000);
        check("irq_request", {31'h0, irqRequest}, 32'h0);
        @(posedge sysClk) irqLines <= 32'h0000_0800;
        i_pipe.csr_write(12'h304, trap_csr_pkg::CSR_SET, 32'h0000_0800);
        rd(12'h304, 32'h0000_0800);
        check("irq_request", {31'h0, irqRequest}, 32'h1);
        @(posedge sysClk) debugMode <= 1'b1;
        i_pipe.csr_write(12'h7a1, trap_csr_pkg::CSR_WRITE, 32'hffff_ffff);
        rd(12'h7a1, 32'h2800_1044);
        i_pipe.csr_write(12'h7a2, trap_csr_pkg::CSR_WRITE, 32'h0000_0100);
        rd(12'h7a2, 32'h0000_0100);
        @(posedge sysClk) debugMode <= 1'b0;
        i_pipe.csr_write(12'h7a2, trap_csr_pkg::CSR_WRITE, 32'h0000_0200);
        rd(12'h7a2, 32'h0000_0100);
        i_pipe.event_pulse(3, 32'h0000_0100, 5'h00);
        check("trigger_hit", {31'h0, debugTriggerHit}, 32'h1);
        i_pipe.event_pulse(3, 32'h0000_0104, 5'h00);
        check("trigger_hit", {31'h0, debugTriggerHit}, 32'h0);
        @(posedge sysClk) privLevel <= 2'h0;
        rd(12'h7a4, 32'h0000_0000);
        rd(12'h7a2, 32'h0000_0000);
        conclude();
    end
endmodule
`default_nettype wire
